// [design/mlcd_row_driver.sv]
// serial matrix display row driver: link-side shift register, frame phase and display latches
// assumes the host shifts on falling edges of shift_clk and keeps them clear of refresh_req rises
//
// Operation
// - every falling shift clock edge shifts one serial bit into the register.
// - a latched one makes its element visible, a zero leaves it blank.
// - each refresh request rise copies the whole register into the display latches.
// - selected rows drive opposite to refresh phase; unselected rows sit at midpoint.
// - columns follow refresh phase when selected, opposite phase when not.
// - refresh request is an exact half-high square wave, rising with each transfer.
// - with the phase input driven externally, refresh request follows that input.
// - first bit shifted ends on last column, final bit on first row.
// - eight row outputs and twenty-six column outputs are provided.
module mlcd_row_driver #(
   parameter int PHASE_HALF = mlcd_pkg::PHASE_HALF_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      shift_clk,
   input  wire logic                      serial_din,
   input  wire logic                      frame_phase_in,
   input  wire logic                      ext_phase_en,
   output logic                           refresh_req,
   output logic [mlcd_pkg::ROWS-1:0]      row_level,
   output logic [mlcd_pkg::ROWS-1:0]      row_mid,
   output logic [mlcd_pkg::COLS-1:0]      col_level
);
   localparam int ROWS = mlcd_pkg::ROWS;
   localparam int COLS = mlcd_pkg::COLS;
   localparam int W    = mlcd_pkg::WORD;
   localparam int CW   = $clog2(PHASE_HALF + 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(PHASE_HALF - 1);
   localparam logic [CW-1:0] CNT_ONE   = CW'(1);

   if (PHASE_HALF < 2) begin : g_bad_half
      $error("mlcd_row_driver: PHASE_HALF must be at least 2");
   end
   if (W != 34) begin : g_bad_word
      $error("mlcd_row_driver: word layout must be 34 bits");
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain: runs only while the host clocks data in

   logic [1:0]   lrst_q;
   logic [W-1:0] shreg_q;
   logic         tog_q;

   // reset reaches the link side through its own synchroniser
   always_ff @(negedge shift_clk) begin
      lrst_q <= {lrst_q[0], rstn};
   end

   // newest bit enters at bit 0, so after a full load bit 0 is the first row
   always_ff @(negedge shift_clk) begin
      shreg_q <= {shreg_q[W-2:0], serial_din};
   end

   // one toggle per shift tells the system side the word moved
   always_ff @(negedge shift_clk) begin
      if (!lrst_q[1]) begin
         tog_q <= mlcd_pkg::RST_TOGGLE;
      end else begin
         tog_q <= ~tog_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // crossing into the system clock

   logic [2:0]   sync_w;
   logic         tog_prev_q;
   logic [W-1:0] mirror_q;
   logic         tog_evt;
   logic         ext_w;
   logic         ext_phase_w;

   mlcd_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk (clk),
      .d   ({tog_q, ext_phase_en, frame_phase_in}),
      .q   (sync_w)
   );

   assign tog_evt     = sync_w[2] ^ tog_prev_q;
   assign ext_w       = sync_w[1];
   assign ext_phase_w = sync_w[0];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tog_prev_q <= mlcd_pkg::RST_TOGGLE;
      end else begin
         tog_prev_q <= sync_w[2];
      end
   end

   // the word is quiet for many system cycles between shifts, so sampling it
   // after the toggle has crossed is safe; a shift racing a transfer is not
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mirror_q <= '0;
      end else if (tog_evt) begin
         mirror_q <= shreg_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame phase: internal divider or the external phase input

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          osc_q;
   logic          osc_d;
   logic          half_end;
   logic          phase_d;
   logic          phase_rise;

   assign half_end   = (cnt_q == HALF_LAST);
   assign cnt_d      = (ext_w || half_end) ? '0 : cnt_q + CNT_ONE;
   assign osc_d      = (!ext_w && half_end) ? ~osc_q : osc_q;
   assign phase_d    = ext_w ? ext_phase_w : osc_d;
   assign phase_rise = phase_d & ~refresh_req;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= '0;
         osc_q <= mlcd_pkg::RST_PHASE;
      end else begin
         cnt_q <= cnt_d;
         osc_q <= osc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // display latches and output drive

   logic [W-1:0]    latch_q;
   logic [W-1:0]    latch_d;
   logic [ROWS-1:0] row_sel;
   logic [COLS-1:0] col_on;
   logic [ROWS-1:0] row_level_d;
   logic [COLS-1:0] col_level_d;

   assign latch_d     = phase_rise ? mirror_q : latch_q;
   assign row_sel     = latch_d[mlcd_pkg::ROW_LSB +: ROWS];
   assign col_on      = latch_d[mlcd_pkg::COL_LSB +: COLS];
   assign row_level_d = row_sel & ~{ROWS{phase_d}};
   // a set bit keeps the column in phase, which puts the full swing on the element
   assign col_level_d = ~(col_on ^ {COLS{phase_d}});

   always_ff @(posedge clk) begin
      if (!rstn) begin
         latch_q     <= '0;
         refresh_req <= mlcd_pkg::RST_PHASE;
         row_level   <= '0;
         row_mid     <= '1;
         col_level   <= '1;
      end else begin
         latch_q     <= latch_d;
         refresh_req <= phase_d;
         row_level   <= row_level_d;
         row_mid     <= ~row_sel;
         col_level   <= col_level_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic [CW-1:0] run_q;
   logic          clean_q;

   // cycles since the last refresh edge; clean while no external phase seen
   always_ff @(posedge clk) begin
      if (!rstn) begin
         run_q   <= '0;
         clean_q <= 1'b0;
      end else if (refresh_req != phase_d) begin
         run_q   <= '0;
         clean_q <= !ext_w;
      end else begin
         run_q   <= (run_q == '1) ? run_q : run_q + CNT_ONE;
         clean_q <= clean_q && !ext_w;
      end
   end

   // the register has no reset, so bits not yet loaded since power-up are compared as they stand
   shift_order_a: assert property (@(negedge shift_clk) disable iff (!rstn || !lrst_q[1])
      shreg_q === {$past(shreg_q[W-2:0]), $past(serial_din)})
      else $error("shift register did not take the serial bit at bit 0");

   latch_xfer_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(refresh_req) |-> latch_q == $past(mirror_q))
      else $error("latches not loaded on refresh rise");

   latch_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !$rose(refresh_req) |-> $stable(latch_q))
      else $error("latches changed without a refresh rise");

   row_drive_a: assert property (@(posedge clk) disable iff (!rstn)
      ##1 (row_mid == ~latch_q[ROWS-1:0]) && (row_level == (latch_q[ROWS-1:0] & ~{ROWS{refresh_req}})))
      else $error("row drive does not match selection and phase");

   col_drive_a: assert property (@(posedge clk) disable iff (!rstn)
      ##1 col_level == ~(latch_q[W-1:ROWS] ^ {COLS{refresh_req}}))
      else $error("column drive does not match pixel and phase");

   duty_half_a: assert property (@(posedge clk) disable iff (!rstn)
      (clean_q && !ext_w && $changed(refresh_req) && $past(clean_q)) |-> $past(run_q) == HALF_LAST)
      else $error("internal refresh half period is wrong");

   duty_max_a: assert property (@(posedge clk) disable iff (!rstn)
      (clean_q && !ext_w) |-> run_q <= HALF_LAST)
      else $error("internal refresh half period overran");

   ext_follow_a: assert property (@(posedge clk) disable iff (!rstn)
      (ext_w && $past(ext_w)) |=> refresh_req == $past(ext_phase_w))
      else $error("refresh request does not follow external phase");

   mirror_take_a: assert property (@(posedge clk) disable iff (!rstn)
      !tog_evt |=> $stable(mirror_q))
      else $error("word sampled with no shift seen");
endmodule

// [shared/mlcd_pkg.sv]
// constants of the serial matrix row driver: word layout, timing and reset values
// assumes a 250 MHz system clock and a shift clock of at most 1.5 MHz from the host
package mlcd_pkg;
   localparam int ROWS             = 8;
   localparam int COLS             = 26;
   localparam int WORD             = ROWS + COLS;
   localparam int ROW_LSB          = 0;
   localparam int COL_LSB          = ROWS;
   localparam int CLK_HZ           = 250_000_000;
   localparam int CLK_PERIOD_NS    = 4;
   localparam int FLICKER_HZ       = 30;
   localparam int BACKPLANES       = 8;
   localparam int SHIFT_MAX_HZ     = 1_500_000;
   // longest half period: the frame rate must stay above the flicker limit, so round down
   localparam int PHASE_HALF_CYCLES = CLK_HZ / (2 * FLICKER_HZ * BACKPLANES);
   localparam logic RST_PHASE      = 1'b0;
   localparam logic RST_TOGGLE     = 1'b0;
endpackage

// [design/mlcd_sync.sv]
// two-flop level synchroniser, one lane per bit
// assumes each lane is a level or a slow toggle from another clock or a pin
module mlcd_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("mlcd_sync: WIDTH must be at least 1");
   end

   // first stage feeds the second stage only
   always_ff @(posedge clk) begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule

// [tb/mlcd_host_model.sv]
// host partner: shifts one row word into the driver, first bit on the last column
// assumes the caller keeps each load clear of refresh request rises
module mlcd_host_model (
   output logic shift_clk,
   output logic serial_din,
   output logic serial_din_b
);
   timeunit 1ns;
   timeprecision 100ps;
   logic lclk;
   // second device of the cascade gets its own data line, carrying the inverse word
   assign serial_din_b = ~serial_din;
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      shift_clk = 1'b1;
      serial_din = 1'b0;
      lclk = 1'b0;
      #1.3;
      forever #6 lclk = ~lclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one bit per two link periods: falls stay far enough apart for the crossing
   task automatic send_word(input logic [mlcd_pkg::WORD-1:0] w);
      for (int i = mlcd_pkg::WORD - 1; i >= 0; i--) begin
         @(posedge lclk);
         shift_clk = 1'b1;
         serial_din = w[i]; // data moves only while the clock is high
         @(posedge lclk);
         shift_clk = 1'b0;
      end
      @(posedge lclk);
      shift_clk = 1'b1; // clock stands still between loads, so it can act as a select
      serial_din = ~serial_din; // released line shows no stale value
   endtask
   // link reset only clears on falls, so the caller gives a few while rstn is low
   task automatic flush(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge lclk);
         shift_clk = 1'b1;
         serial_din = 1'b0;
         @(posedge lclk);
         shift_clk = 1'b0;
      end
      @(posedge lclk);
      shift_clk = 1'b1;
   endtask
endmodule

// [tb/mlcd_row_driver_tb_top.sv]
// self-checking bench of the row driver with a host partner on the serial link
// assumes the host model and the shared constants package are compiled first
module mlcd_row_driver_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 300;
   logic                      clk, rstn, frame_phase_in, ext_phase_en;
   logic                      shift_clk, serial_din, refresh_req;
   logic [mlcd_pkg::ROWS-1:0] row_level, row_mid;
   logic [mlcd_pkg::COLS-1:0] col_level;
   logic                      serial_din_b, refresh_b;
   logic [mlcd_pkg::ROWS-1:0] row_level_b, row_mid_b;
   logic [mlcd_pkg::COLS-1:0] col_level_b;
   int                        n_errors = 0;
   int                        n_compared = 0;
   ////////////////////////////////////////////////////////////////////////////
   mlcd_row_driver #(.PHASE_HALF(HALF)) u_mlcd_row_driver (.clk(clk), .rstn(rstn), .shift_clk(shift_clk),
      .serial_din(serial_din), .frame_phase_in(frame_phase_in), .ext_phase_en(ext_phase_en),
      .refresh_req(refresh_req), .row_level(row_level), .row_mid(row_mid), .col_level(col_level));
   // cascade: shared shift clock, own data line, phase taken from the first device
   mlcd_row_driver #(.PHASE_HALF(HALF)) u_mlcd_row_driver_cas (.clk(clk), .rstn(rstn), .shift_clk(shift_clk),
      .serial_din(serial_din_b), .frame_phase_in(refresh_req), .ext_phase_en(1'b1),
      .refresh_req(refresh_b), .row_level(row_level_b), .row_mid(row_mid_b), .col_level(col_level_b));
   mlcd_host_model u_mlcd_host_model (.shift_clk(shift_clk), .serial_din(serial_din),
      .serial_din_b(serial_din_b));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (n_errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic fail(input string m);
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   // counts falling clk edges until refresh_req shows lvl
   task automatic wait_ref(input logic lvl, output int n);
      n = 0;
      while (refresh_req !== lvl) begin
         @(negedge clk);
         n++;
         if (n > 2 * HALF + 8) begin
            fail("refresh wait timed out");
            wrap_up();
         end
      end
   endtask
   task automatic check_out(input logic [mlcd_pkg::WORD-1:0] w);
      logic [mlcd_pkg::ROWS-1:0] sel;
      logic [mlcd_pkg::COLS-1:0] pix;
      sel = w[mlcd_pkg::ROWS-1:0];
      pix = w[mlcd_pkg::WORD-1:mlcd_pkg::COL_LSB];
      n_compared++;
      if (row_mid !== ~sel || row_level !== (sel & {mlcd_pkg::ROWS{~refresh_req}})
          || col_level !== (refresh_req ? pix : ~pix)) fail("drive outputs");
   endtask
   task automatic check_cas(input logic [mlcd_pkg::WORD-1:0] w);
      logic [mlcd_pkg::ROWS-1:0] sel;
      logic [mlcd_pkg::COLS-1:0] pix;
      sel = w[mlcd_pkg::ROWS-1:0];
      pix = w[mlcd_pkg::WORD-1:mlcd_pkg::COL_LSB];
      n_compared++;
      if (refresh_b !== refresh_req || row_mid_b !== ~sel || row_level_b !== (sel & {mlcd_pkg::ROWS{~refresh_b}})
          || col_level_b !== (refresh_b ? pix : ~pix)) fail("cascaded drive outputs");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic duty_check;
      int n;
      n_compared++;
      if (2 * mlcd_pkg::PHASE_HALF_CYCLES * mlcd_pkg::BACKPLANES * mlcd_pkg::FLICKER_HZ >= mlcd_pkg::CLK_HZ)
         fail("default frame rate not above flicker limit");
      wait_ref(1'b1, n);
      wait_ref(1'b0, n);
      n_compared++;
      if (n != HALF) fail("high phase length");
      wait_ref(1'b1, n);
      n_compared++;
      if (n != HALF) fail("low phase length");
   endtask
   task automatic scan_rows;
      logic [mlcd_pkg::WORD-1:0] w, prev;
      int n;
      prev = '0;
      for (int r = 0; r < mlcd_pkg::ROWS; r++) begin
         w = {(26'h3FFFFFF >> r), (8'h01 << r)};
         u_mlcd_host_model.send_word(w);
         check_out(prev);
         wait_ref(1'b0, n);
         check_out(prev);
         wait_ref(1'b1, n);
         check_out(w);
         repeat (3) @(negedge clk);
         check_cas(~w);
         prev = w;
      end
   endtask
   task automatic ext_follow;
      logic [mlcd_pkg::WORD-1:0] w;
      w = {26'h2AAAAA5, 8'h80};
      ext_phase_en = 1'b1;
      repeat (10) @(negedge clk);
      u_mlcd_host_model.send_word(w);
      @(negedge clk);
      frame_phase_in = 1'b1;
      repeat (2) @(negedge clk);
      n_compared++;
      if (refresh_req !== 1'b0) fail("refresh rose early");
      @(negedge clk);
      n_compared++;
      if (refresh_req !== 1'b1) fail("refresh not following");
      check_out(w);
      repeat (40) @(negedge clk);
      frame_phase_in = 1'b0;
      repeat (3) @(negedge clk);
      n_compared++;
      if (refresh_req !== 1'b0) fail("refresh not falling");
      check_out(w);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      ext_phase_en = 1'b0;
      frame_phase_in = 1'b0;
      fork
         u_mlcd_host_model.flush(3);
         begin
            repeat (20) @(negedge clk);
            check_out('0);
            rstn = 1'b1;
         end
      join
      // a blank word first, so the first transfer never carries an unloaded register
      u_mlcd_host_model.send_word('0);
      duty_check();
      scan_rows();
      ext_follow();
      wrap_up();
   end
endmodule
